// ===== hw/clock_buffer_global_control_pkg.sv
package clock_buffer_global_control_pkg;

   // Register port widths, channel pair count and function code width
   localparam int ADDR_W  = 7;
   localparam int DATA_W  = 8;
   localparam int PAIRS   = 7;
   localparam int CODE_W  = 4;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFF_GLOBAL_FEATURE = 7'h03;
   localparam logic [ADDR_W-1:0] OFF_PAIR_ENABLE    = 7'h04;
   localparam logic [ADDR_W-1:0] OFF_MODE_SPARE     = 7'h05;
   localparam logic [ADDR_W-1:0] OFF_ALARM_CLEAR    = 7'h06;
   localparam logic [ADDR_W-1:0] OFF_SPARE_A        = 7'h07;
   localparam logic [ADDR_W-1:0] OFF_SCRATCHPAD     = 7'h08;
   localparam logic [ADDR_W-1:0] OFF_SPARE_B        = 7'h09;
   localparam logic [ADDR_W-1:0] OFF_REF_CLK_BUF    = 7'h0A;
   localparam logic [ADDR_W-1:0] OFF_SYNC_REF_BUF   = 7'h0B;
   localparam logic [ADDR_W-1:0] OFF_INPUT_CONTROL  = 7'h46;

   // Values after reset
   localparam logic [DATA_W-1:0] RST_REG     = 8'h00;
   localparam logic [DATA_W-1:0] RST_RD_DATA = 8'h00;

   // Field positions
   localparam int BIT_RADIO_RESEED = 5;
   localparam int BIT_SYSREF_TIMER = 2;
   localparam int BIT_ALARM_CLEAR  = 0;
   localparam int BIT_BUF_ENABLE   = 0;
   localparam int BUF_MODE_LSB     = 1;
   localparam int BUF_MODE_MSB     = 4;
   localparam int BIT_FN_ENABLE    = 0;
   localparam int FN_CODE_LSB      = 1;
   localparam int FN_CODE_MSB      = 4;

   // Input function codes, as held in bits 4 to 1
   localparam logic [CODE_W-1:0] FN_SLEEP   = 4'h2;
   localparam logic [CODE_W-1:0] FN_MUTE    = 4'h3;
   localparam logic [CODE_W-1:0] FN_PULSE   = 4'h4;
   localparam logic [CODE_W-1:0] FN_RESEED  = 4'h5;
   localparam logic [CODE_W-1:0] FN_RESTART = 4'h6;
   localparam logic [CODE_W-1:0] FN_SLIP    = 4'h8;

endpackage

// ===== hw/clock_buffer_global_control.sv
// What this block does
// - Bit 5 of register 0x3 enables reseeding
// - Bit 2 of register 0x3 enables reference timer
// - Bit n enables channels 2n and 2n+1
// - Writing one to alarm bit clears alarms
// - Scratch register reads back, affects nothing
// - Two input buffers, bit 0 enables each
// - Bits 4 to 1 select buffer input modes
// - Select codes give sleep and mute from pin
// - Select codes give pulse and reseed requests
// - Select codes give restart and slip; others ignored
// - Bit 0 enables function; change select while off
// - Pin may be input and output together
// - Sleep disables outputs and buffers while held
// - Mute silences drivers, dividers keep running
// - Reseed on rising edge, only when resync done
// - Restart resets dividers, keeps configuration
module clock_buffer_global_control
   import clock_buffer_global_control_pkg::*;
(
   input  wire logic                                  clk,
   input  wire logic                                  clkEn,
   input  wire logic                                  sys_rst,
   input  wire logic [clock_buffer_global_control_pkg::ADDR_W-1:0] regAddr,
   input  wire logic                                  regWrEn,
   input  wire logic [clock_buffer_global_control_pkg::DATA_W-1:0] regWrData,
   input  wire logic                                  regRdEn,
   output logic      [clock_buffer_global_control_pkg::DATA_W-1:0] regRdData,
   input  wire logic                                  generalInputPin,
   input  wire logic                                  resyncDone,
   output logic                                       radioReseedEnable,
   output logic                                       sysrefTimerEnable,
   output logic [2*clock_buffer_global_control_pkg::PAIRS-1:0] channelEnable,
   output logic                                       alarmClear,
   output logic                                       refClockBufEnable,
   output logic      [3:0]                            refClockBufMode,
   output logic                                       syncRefBufEnable,
   output logic      [3:0]                            syncRefBufMode,
   output logic                                       sleepReq,
   output logic                                       muteReq,
   output logic                                       pulseGenReq,
   output logic                                       reseedReq,
   output logic                                       restartReq,
   output logic                                       slipReq
);
   import clock_buffer_global_control_pkg::*;

   // Stored registers
   logic [DATA_W-1:0] featureEn_q;
   logic [DATA_W-1:0] pairEn_q;
   logic [DATA_W-1:0] modeSpare_q;
   logic [DATA_W-1:0] alarmReg_q;
   logic [DATA_W-1:0] spareA_q;
   logic [DATA_W-1:0] scratch_q;
   logic [DATA_W-1:0] spareB_q;
   logic [DATA_W-1:0] refBuf_q;
   logic [DATA_W-1:0] syncBuf_q;
   logic [DATA_W-1:0] inputCtl_q;

   // Pin synchroniser and edge history
   logic pinMeta_q;
   logic pinSync_q;
   logic pinPrev_q;

   // Write decode
   logic wrAny;
   logic wrFeature;
   logic wrPair;
   logic wrModeSpare;
   logic wrAlarm;
   logic wrSpareA;
   logic wrScratch;
   logic wrSpareB;
   logic wrRefBuf;
   logic wrSyncBuf;
   logic wrInputCtl;
   logic alarmHit;

   assign wrAny       = clkEn && regWrEn;
   assign wrFeature   = wrAny && (regAddr == OFF_GLOBAL_FEATURE);
   assign wrPair      = wrAny && (regAddr == OFF_PAIR_ENABLE);
   assign wrModeSpare = wrAny && (regAddr == OFF_MODE_SPARE);
   assign wrAlarm     = wrAny && (regAddr == OFF_ALARM_CLEAR);
   assign wrSpareA    = wrAny && (regAddr == OFF_SPARE_A);
   assign wrScratch   = wrAny && (regAddr == OFF_SCRATCHPAD);
   assign wrSpareB    = wrAny && (regAddr == OFF_SPARE_B);
   assign wrRefBuf    = wrAny && (regAddr == OFF_REF_CLK_BUF);
   assign wrSyncBuf   = wrAny && (regAddr == OFF_SYNC_REF_BUF);
   assign wrInputCtl  = wrAny && (regAddr == OFF_INPUT_CONTROL);
   assign alarmHit    = wrAlarm && regWrData[BIT_ALARM_CLEAR];

   // Read selection; unmapped offsets read as zero
   logic [DATA_W-1:0] rdMux;

   assign rdMux =
      (regAddr == OFF_GLOBAL_FEATURE) ? featureEn_q :
      (regAddr == OFF_PAIR_ENABLE)    ? pairEn_q    :
      (regAddr == OFF_MODE_SPARE)     ? modeSpare_q :
      (regAddr == OFF_ALARM_CLEAR)    ? alarmReg_q  :
      (regAddr == OFF_SPARE_A)        ? spareA_q    :
      (regAddr == OFF_SCRATCHPAD)     ? scratch_q   :
      (regAddr == OFF_SPARE_B)        ? spareB_q    :
      (regAddr == OFF_REF_CLK_BUF)    ? refBuf_q    :
      (regAddr == OFF_SYNC_REF_BUF)   ? syncBuf_q   :
      (regAddr == OFF_INPUT_CONTROL)  ? inputCtl_q  :
      RST_RD_DATA;

   // Register storage; every bit, reserved or not, keeps what was written
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         featureEn_q <= RST_REG;
         pairEn_q    <= RST_REG;
         modeSpare_q <= RST_REG;
         alarmReg_q  <= RST_REG;
         spareA_q    <= RST_REG;
         scratch_q   <= RST_REG;
         spareB_q    <= RST_REG;
         refBuf_q    <= RST_REG;
         syncBuf_q   <= RST_REG;
         inputCtl_q  <= RST_REG;
      end
      else
      begin
         if (wrFeature)   featureEn_q <= regWrData;
         if (wrPair)      pairEn_q    <= regWrData;
         if (wrModeSpare) modeSpare_q <= regWrData;
         if (wrAlarm)     alarmReg_q  <= regWrData;
         if (wrSpareA)    spareA_q    <= regWrData;
         if (wrScratch)   scratch_q   <= regWrData;
         if (wrSpareB)    spareB_q    <= regWrData;
         if (wrRefBuf)    refBuf_q    <= regWrData;
         if (wrSyncBuf)   syncBuf_q   <= regWrData;
         if (wrInputCtl)  inputCtl_q  <= regWrData;
      end
   end

   // Read data is captured on a read strobe and held until the next one
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         regRdData <= RST_RD_DATA;
      else if (clkEn && regRdEn)
         regRdData <= rdMux;
   end

   // Two-stage pin synchroniser plus history for edge detection
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pinMeta_q <= 1'b0;
         pinSync_q <= 1'b0;
         pinPrev_q <= 1'b0;
      end
      else if (clkEn)
      begin
         pinMeta_q <= generalInputPin;
         pinSync_q <= pinMeta_q;
         pinPrev_q <= pinSync_q;
      end
   end

   // Input function decode; pin is only read, so output use never clashes
   logic              fnOn;
   logic [CODE_W-1:0] fnCode;
   logic              pinHigh;
   logic              pinRise;

   assign fnOn    = inputCtl_q[BIT_FN_ENABLE];
   assign fnCode  = inputCtl_q[FN_CODE_MSB:FN_CODE_LSB];
   assign pinHigh = fnOn && pinSync_q;
   assign pinRise = fnOn && pinSync_q && !pinPrev_q;

   // Levels follow the pin; events fire once per rising edge
   logic sleepD;
   logic muteD;
   logic pulseD;
   logic reseedD;
   logic restartD;
   logic slipD;

   assign sleepD   = pinHigh && (fnCode == FN_SLEEP);
   assign muteD    = pinHigh && (fnCode == FN_MUTE);
   assign pulseD   = pinHigh && (fnCode == FN_PULSE);
   assign reseedD  = pinRise && (fnCode == FN_RESEED)
                     && resyncDone;
   assign restartD = pinRise && (fnCode == FN_RESTART);
   assign slipD    = pinRise && (fnCode == FN_SLIP);

   // Pair enables fan out to both channels of each pair
   logic [PAIRS-1:0]   pairBits;
   logic [2*PAIRS-1:0] chanD;

   assign pairBits = pairEn_q[PAIRS-1:0];

   for (genvar p = 0; p < PAIRS; p++)
   begin : g_pair
      assign chanD[2*p]   = pairBits[p] && !sleepD;
      assign chanD[2*p+1] = pairBits[p] && !sleepD;
   end

   // Buffer controls; sleep shuts both buffers, mode bits pass through
   logic refEnD;
   logic syncEnD;

   assign refEnD  = refBuf_q[BIT_BUF_ENABLE] && !sleepD;
   assign syncEnD = syncBuf_q[BIT_BUF_ENABLE] && !sleepD;

   // Output flops: controls and requests
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         radioReseedEnable <= 1'b0;
         sysrefTimerEnable <= 1'b0;
         channelEnable     <= '0;
         alarmClear        <= 1'b0;
         refClockBufEnable <= 1'b0;
         refClockBufMode   <= '0;
         syncRefBufEnable  <= 1'b0;
         syncRefBufMode    <= '0;
         sleepReq          <= 1'b0;
         muteReq           <= 1'b0;
         pulseGenReq       <= 1'b0;
         reseedReq         <= 1'b0;
         restartReq        <= 1'b0;
         slipReq           <= 1'b0;
      end
      else if (clkEn)
      begin
         radioReseedEnable <= featureEn_q[BIT_RADIO_RESEED];
         sysrefTimerEnable <= featureEn_q[BIT_SYSREF_TIMER];
         channelEnable     <= chanD;
         alarmClear        <= alarmHit;
         refClockBufEnable <= refEnD;
         refClockBufMode   <= refBuf_q[BUF_MODE_MSB:BUF_MODE_LSB];
         syncRefBufEnable  <= syncEnD;
         syncRefBufMode    <= syncBuf_q[BUF_MODE_MSB:BUF_MODE_LSB];
         sleepReq          <= sleepD;
         muteReq           <= muteD;
         pulseGenReq       <= pulseD;
         reseedReq         <= reseedD;
         restartReq        <= restartD;
         slipReq           <= slipD;
      end
   end

   // Checks below watch only what this block drives

   // Scratch write is visible on the next read
   property pScratch;
      @(posedge clk) disable iff (sys_rst)
      wrScratch |=> (scratch_q == $past(regWrData));
   endproperty
   AST_SCRATCH_READBACK: assert property (pScratch)
      else $error("scratch register lost written value");

   // Reseed enable reaches its output two enabled edges after write
   property pReseedEn;
      @(posedge clk) disable iff (sys_rst)
      (wrFeature ##1 (clkEn && !wrFeature))
      |=> (radioReseedEnable == $past(regWrData[BIT_RADIO_RESEED], 2));
   endproperty
   AST_RESEED_ENABLE: assert property (pReseedEn)
      else $error("reseed enable does not follow register bit");

   // Timer enable tracks its bit the same way
   property pTimerEn;
      @(posedge clk) disable iff (sys_rst)
      (wrFeature ##1 (clkEn && !wrFeature))
      |=> (sysrefTimerEnable == $past(regWrData[BIT_SYSREF_TIMER], 2));
   endproperty
   AST_TIMER_ENABLE: assert property (pTimerEn)
      else $error("timer enable does not follow register bit");

   // Both channels of a pair always agree
   logic [PAIRS-1:0] evenCh;
   logic [PAIRS-1:0] oddCh;

   for (genvar q = 0; q < PAIRS; q++)
   begin : g_chk
      assign evenCh[q] = channelEnable[2*q];
      assign oddCh[q]  = channelEnable[2*q+1];
   end

   AST_PAIR_MATCH: assert property (
      @(posedge clk) disable iff (sys_rst) evenCh == oddCh)
      else $error("channels of one pair disagree");

   // Alarm clear pulses only after a write of one to its bit
   AST_ALARM_CLEAR: assert property (
      @(posedge clk) disable iff (sys_rst)
      (alarmClear && !$past(clkEn)) || !alarmClear || $past(alarmHit))
      else $error("alarm clear without matching write");

   // Sleep shuts every output and buffer
   AST_SLEEP_SHUTDOWN: assert property (
      @(posedge clk) disable iff (sys_rst)
      sleepReq |-> (!refClockBufEnable && !syncRefBufEnable
                    && (channelEnable == '0)))
      else $error("outputs active during sleep");

   // Reseed fires only while resync reports done
   AST_RESEED_GATE: assert property (
      @(posedge clk) disable iff (sys_rst)
      $rose(reseedReq) |-> $past(resyncDone))
      else $error("reseed issued while resync busy");

   // Restart follows a pin rising edge selected for restart
   sequence sRestartSel;
      clkEn && fnOn && (fnCode == FN_RESTART);
   endsequence

   sequence sPinEdge;
      pinSync_q && !pinPrev_q;
   endsequence

   property pRestart;
      @(posedge clk) disable iff (sys_rst)
      (sRestartSel ##0 sPinEdge) |=> restartReq ##0 !slipReq;
   endproperty
   AST_RESTART_EDGE: assert property (pRestart)
      else $error("restart edge not issued");

   // Mute follows the pin level without touching sleep
   AST_MUTE_LEVEL: assert property (
      @(posedge clk) disable iff (sys_rst)
      (clkEn && fnOn && (fnCode == FN_MUTE) && pinSync_q)
      |=> (muteReq && !sleepReq))
      else $error("mute not held while pin high");

   // With the function disabled no request leaves
   AST_FUNCTION_OFF: assert property (
      @(posedge clk) disable iff (sys_rst)
      (clkEn && !fnOn) |=> !(sleepReq || muteReq || pulseGenReq
                             || reseedReq || restartReq || slipReq))
      else $error("request issued with function disabled");

endmodule

// ===== test/pin_source_model.sv
module pin_source_model
(
   input  wire logic clk,
   input  wire logic pinLevel,
   input  wire logic doneLevel,
   output logic      generalInputPin,
   output logic      resyncDone
);
   timeunit 1ns;
   timeprecision 100ps;

   // Quiet pin and busy resync machine until told otherwise
   initial
   begin
      generalInputPin = 1'b0;
      resyncDone      = 1'b0;
   end

   // Board logic moves the pin off the clock grid, so the synchroniser works
   always @(pinLevel) generalInputPin <= #3 pinLevel;

   // Resync machine status is a same-clock level, changing after the edge
   always @(posedge clk) resyncDone <= #1 doneLevel;
endmodule

// ===== test/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import clock_buffer_global_control_pkg::*;

   logic              clk, clkEn, sys_rst, regWrEn, regRdEn;
   logic              pinLevel, doneLevel, generalInputPin, resyncDone;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWrData, regRdData;
   logic              radioReseedEnable, sysrefTimerEnable, alarmClear;
   logic [13:0]       channelEnable;
   logic              refClockBufEnable, syncRefBufEnable;
   logic [3:0]        refClockBufMode, syncRefBufMode;
   logic              sleepReq, muteReq, pulseGenReq;
   logic              reseedReq, restartReq, slipReq;
   logic [5:0]        reqs;
   int                fails, n_checks;

   // Requests gathered in function-code order
   assign reqs = {slipReq, restartReq, reseedReq, pulseGenReq, muteReq,
                  sleepReq};

   clock_buffer_global_control dut (.clk(clk), .clkEn(clkEn),
      .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
      .generalInputPin(generalInputPin), .resyncDone(resyncDone),
      .radioReseedEnable(radioReseedEnable),
      .sysrefTimerEnable(sysrefTimerEnable),
      .channelEnable(channelEnable), .alarmClear(alarmClear),
      .refClockBufEnable(refClockBufEnable),
      .refClockBufMode(refClockBufMode),
      .syncRefBufEnable(syncRefBufEnable), .syncRefBufMode(syncRefBufMode),
      .sleepReq(sleepReq), .muteReq(muteReq), .pulseGenReq(pulseGenReq),
      .reseedReq(reseedReq), .restartReq(restartReq), .slipReq(slipReq));

   pin_source_model far (.clk(clk), .pinLevel(pinLevel),
      .doneLevel(doneLevel), .generalInputPin(generalInputPin),
      .resyncDone(resyncDone));

   // Free-running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic finish_test();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One-cycle write strobe, launched and dropped on falling edges
   task automatic wr(logic [6:0] a, logic [7:0] d);
      @(negedge clk);
      regAddr   = a;
      regWrData = d;
      regWrEn   = 1'b1;
      @(negedge clk);
      regWrEn   = 1'b0;
   endtask

   task automatic rd(logic [6:0] a, logic [7:0] exp);
      @(negedge clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk);
      regRdEn = 1'b0;
      check("read data", 16'(exp), 16'(regRdData));
   endtask

   // Pair enable bit n drives channels 2n and 2n+1
   function automatic logic [13:0] pairs(logic [7:0] v);
      for (int i = 0; i < 7; i++)
         pairs[2*i+:2] = {2{v[i]}};
   endfunction

   task automatic t_regs();
      logic [6:0] adr [9];
      logic [7:0] val [9];
      adr = '{7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h46};
      val = '{8'he5, 8'haa, 8'h5a, 8'hfe, 8'ha5, 8'hc3, 8'h3c, 8'hf5, 8'h00};
      foreach (adr[i]) rd(adr[i], 8'h00);
      check("channels", 16'h0000, 16'(channelEnable));
      foreach (adr[i]) wr(adr[i], val[i]);
      wr(7'h0b, 8'h0b);
      wr(7'h10, 8'hff);
      foreach (adr[i]) rd(adr[i], val[i]);
      rd(7'h10, 8'h00);
      check("reseed enable", 16'h0001, 16'(radioReseedEnable));
      check("timer enable", 16'h0001, 16'(sysrefTimerEnable));
      check("channels", 16'(pairs(8'haa)), 16'(channelEnable));
      check("ref buffer", 16'h0015, {11'h0, refClockBufMode,
                                     refClockBufEnable});
      check("sync buffer", 16'h000b, {11'h0, syncRefBufMode,
                                      syncRefBufEnable});
      check("alarm clear", 16'h0000, 16'(alarmClear));
      wr(7'h03, 8'hdb);
      wr(7'h04, 8'h7f);
      repeat (2) @(negedge clk);
      check("reseed enable", 16'h0000, 16'(radioReseedEnable));
      check("timer enable", 16'h0000, 16'(sysrefTimerEnable));
      check("channels", 16'h3fff, 16'(channelEnable));
      clkEn = 1'b0;
      wr(7'h08, 8'h11);
      clkEn = 1'b1;
      rd(7'h08, 8'hc3);
   endtask

   task automatic t_alarm();
      wr(7'h06, 8'h01);
      check("alarm clear", 16'h0001, 16'(alarmClear));
      @(negedge clk);
      check("alarm clear", 16'h0000, 16'(alarmClear));
      rd(7'h06, 8'h01);
   endtask

   // Select a function the safe way, then pulse the pin and watch requests
   task automatic t_pin(logic [3:0] code, logic en, logic done,
                        logic [5:0] e1, logic [5:0] e2);
      doneLevel = done;
      wr(7'h46, 8'h00);
      wr(7'h46, {3'h0, code, 1'b0});
      if (en)
         wr(7'h46, {3'h0, code, 1'b1});
      pinLevel = 1'b1;
      repeat (3) @(negedge clk);
      check("requests", 16'(e1), 16'(reqs));
      if (code == FN_SLEEP && en)
      begin
         check("channels", 16'h0000, 16'(channelEnable));
         check("buffers", 16'h0000, 16'({refClockBufEnable,
                                          syncRefBufEnable}));
      end
      @(negedge clk);
      check("requests", 16'(e2), 16'(reqs));
      pinLevel = 1'b0;
      repeat (3) @(negedge clk);
      check("requests", 16'h0000, 16'(reqs));
      check("channels", 16'h3fff, 16'(channelEnable));
   endtask

   // Watchdog against a hang
   initial
   begin
      #200us;
      fails++;
      finish_test();
   end

   initial
   begin
      {clkEn, regWrEn, regRdEn, pinLevel, doneLevel} = 5'h10;
      {regAddr, regWrData} = '0;
      sys_rst = 1'b1;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      t_regs();
      t_alarm();
      t_pin(FN_SLEEP, 1'b1, 1'b1, 6'h01, 6'h01);
      t_pin(FN_MUTE, 1'b1, 1'b1, 6'h02, 6'h02);
      t_pin(FN_PULSE, 1'b1, 1'b1, 6'h04, 6'h04);
      t_pin(FN_RESEED, 1'b1, 1'b1, 6'h08, 6'h00);
      t_pin(FN_RESEED, 1'b1, 1'b0, 6'h00, 6'h00);
      t_pin(FN_RESTART, 1'b1, 1'b1, 6'h10, 6'h00);
      t_pin(FN_SLIP, 1'b1, 1'b1, 6'h20, 6'h00);
      t_pin(4'h7, 1'b1, 1'b1, 6'h00, 6'h00);
      t_pin(FN_SLIP, 1'b0, 1'b1, 6'h00, 6'h00);
      finish_test();
   end
endmodule
